// File: hdl/conv_host.sv
// Functional notes
// R1: MODE pin low selects read protocol, high selects write-then-read protocol.
// R2: Device decodes channel address bits as binary input index.
// R3: Read mode: host starts conversion by lowering chip select and read.
// R4: Read mode: host holds read low until result appears.
// R5: Read mode: shared write/ready pin is open-drain ready output.
// R6: Ready goes low after chip select falls, high at conversion end.
// R7: Done output asserts at end, clears on rising chip select or read.
// R8: Selected input must be tracked for acquisition interval before conversion.
// R9: Write-read mode: falling write strobe starts conversion.
// R10: Rising write latches upper four bits, starts lower nibble conversion.
// R11: At end, done goes low and lower four bits latch.
// R12: Host waits acquisition interval after done falls before next write.
// R13: Internal delay: host waits for done, then reads with read strobe.
// R14: Device clears done on rising chip select or read strobe.
// R15: Fastest option: read lowered after write rises, before done falls.
// R16: Early read completes conversion immediately and enables output drivers.
// R17: Early read: done asserts after read falls, clears on its rise.
// R18: Write width plus write-to-read plus access equals conversion time.
// R19: Pipelined operation ties write strobe and read strobe together.
// R20: Pipelined: one joined pulse starts conversion and returns previous result.
// R21: Lower reference gives code zero, upper reference gives all ones.
// R22: After power-up host does one dummy conversion, discarding its data.
// R23: Chip select must be low for device to respond to strobes.
// R24: Data outputs are high impedance unless chip select and read low; the device model drives the inverted latch instead.
`timescale 1ns/1ps
module conv_host
   import conv_host_pkg::*;
(
   // Clock and reset
   input  wire logic       CLOCK,
   input  wire logic       RST_N,
   // User side
   input  wire request_t   REQ,
   output logic            BUSY,
   output logic            RESULT_VALID,
   output logic [7:0]      RESULT,
   output logic            TIMEOUT,
   // Converter pins
   output logic            MODE,
   output logic            CS_N,
   output logic            RD_N,
   output logic            WR_N,
   output logic            WR_N_OE,
   input  wire logic       RDY,
   input  wire logic       DONE_N,
   input  wire logic [7:0] RESULT_BUS,
   output logic [2:0]      CHANNEL_ADDR
);

   host_state_t s_r;
   host_state_t s_nxt;
   logic        rdy_q;
   logic        done_q;
   logic        cnt_zero;

   // Second and third stages agree before a pin change counts.
   // A lone disagreeing sample keeps the last accepted level, so glitches are ignored.
   assign rdy_q    = (s_r.rdy_s[1] == s_r.rdy_s[2]) ? s_r.rdy_s[2] : s_r.rdy_f;
   assign done_q   = (s_r.done_s[1] == s_r.done_s[2]) ? s_r.done_s[2] : s_r.done_f;
   assign cnt_zero = (s_r.cnt == '0);

   // ----------------------------------------------------------------
   // Sequencer.
   // ----------------------------------------------------------------
   always_comb begin
      s_nxt        = s_r;
      s_nxt.valid  = 1'b0;
      s_nxt.rdy_s  = {s_r.rdy_s[1:0], RDY};
      s_nxt.done_s = {s_r.done_s[1:0], DONE_N};
      s_nxt.rdy_f  = rdy_q;
      s_nxt.done_f = done_q;
      if (!cnt_zero) begin
         s_nxt.cnt = s_r.cnt - 1'b1;
      end
      unique case (s_r.st)
         ST_IDLE: begin
            s_nxt.busy = 1'b0;
            if (REQ.start || !s_r.primed) begin
               s_nxt.busy    = 1'b1;
               s_nxt.timeout = 1'b0;
               // R22: dummy first conversion
               s_nxt.discard = !s_r.primed;
               // R1: mode pin level
               // The dummy conversion always runs in read mode on channel 0.
               s_nxt.mode    = REQ.mode_wr & s_r.primed;
               s_nxt.option  = REQ.option;
               // R2: binary channel index
               s_nxt.addr    = s_r.primed ? REQ.channel : 3'h0;
               // R8: track before start
               s_nxt.cnt     = CNT_W'(ACQ_CYC - 1);
               s_nxt.st      = ST_ACQ;
            end
         end
         ST_ACQ: begin
            if (cnt_zero) begin
               // R23: select lowered in the same cycle as the strobes
               s_nxt.cs_n = 1'b0;
               if (!s_r.mode) begin
                  // R3: read starts conversion
                  s_nxt.rd_n = 1'b0;
                  s_nxt.cnt  = CNT_W'(RDY_TIMEOUT_CYC);
                  s_nxt.st   = ST_RD_WAIT;
               end else begin
                  // R9: falling write starts
                  s_nxt.wr_n = 1'b0;
                  // R19: joined strobes in pipelined use
                  if (s_r.option == OPT_PIPE) begin
                     s_nxt.rd_n = 1'b0;
                  end
                  s_nxt.cnt  = CNT_W'(WR_PULSE_CYC - 1);
                  s_nxt.st   = ST_WR_LOW;
               end
            end
         end
         ST_RD_WAIT: begin
            // R6: ready low then released high
            if (s_r.cnt < CNT_W'(RDY_TIMEOUT_CYC - 2) && rdy_q) begin
               s_nxt.cnt = CNT_W'(READ_ACCESS_CYC - 1);
               s_nxt.st  = ST_RD_HOLD;
            end else if (cnt_zero) begin
               s_nxt.timeout = 1'b1;
               s_nxt.st      = ST_END;
            end
         end
         ST_RD_HOLD: begin
            // R4: read held until data valid
            if (cnt_zero) begin
               s_nxt.data = RESULT_BUS;
               s_nxt.st   = ST_END;
            end
         end
         ST_WR_LOW: begin
            if (cnt_zero) begin
               // R10: rising write latches upper nibble
               s_nxt.wr_n = 1'b1;
               if (s_r.option == OPT_PIPE) begin
                  // R20: previous result read in the same pulse
                  s_nxt.data = RESULT_BUS;
                  s_nxt.rd_n = 1'b1;
                  s_nxt.st   = ST_END;
               end else if (s_r.option == OPT_EARLY) begin
                  s_nxt.cnt = CNT_W'(WR_TO_RD_CYC - 1);
                  s_nxt.st  = ST_WR_GAP;
               end else begin
                  s_nxt.cnt = CNT_W'(RDY_TIMEOUT_CYC);
                  s_nxt.st  = ST_WAIT_DONE;
               end
            end
         end
         ST_WR_GAP: begin
            // R15: read before internal delay ends
            if (cnt_zero) begin
               s_nxt.rd_n = 1'b0;
               // R18: access closes the conversion time
               s_nxt.cnt  = CNT_W'(READ_ACCESS_CYC - 1);
               s_nxt.st   = ST_READ;
            end
         end
         ST_WAIT_DONE: begin
            // R13: wait for done, then read
            if (!done_q) begin
               s_nxt.rd_n = 1'b0;
               s_nxt.cnt  = CNT_W'(READ_ACCESS_CYC - 1);
               s_nxt.st   = ST_READ;
            end else if (cnt_zero) begin
               s_nxt.timeout = 1'b1;
               s_nxt.st      = ST_END;
            end
         end
         ST_READ: begin
            if (cnt_zero) begin
               s_nxt.data = RESULT_BUS;
               s_nxt.st   = ST_END;
            end
         end
         ST_END: begin
            // R14: rising strobes clear done
            s_nxt.rd_n   = 1'b1;
            s_nxt.wr_n   = 1'b1;
            s_nxt.cs_n   = 1'b1;
            s_nxt.primed = 1'b1;
            s_nxt.valid  = !s_r.discard && !s_r.timeout;
            // R12: acquisition gap before next write
            s_nxt.cnt    = CNT_W'(ACQ_CYC);
            s_nxt.st     = ST_IDLE;
         end
      endcase
      // A new request is not taken in idle until the gap has elapsed; BUSY stays high meanwhile.
      if (s_r.st == ST_IDLE && !cnt_zero) begin
         s_nxt.st   = ST_IDLE;
         s_nxt.cnt  = s_r.cnt - 1'b1;
         s_nxt.busy = 1'b1;
         s_nxt.mode = s_r.mode;
         s_nxt.addr = s_r.addr;
         s_nxt.option = s_r.option;
         s_nxt.discard = s_r.discard;
         s_nxt.timeout = s_r.timeout;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         s_r         <= '0;
         s_r.st      <= ST_IDLE;
         s_r.cs_n    <= 1'b1;
         s_r.rd_n    <= 1'b1;
         s_r.wr_n    <= 1'b1;
         s_r.busy    <= 1'b1;
         s_r.rdy_s   <= 3'h7;
         s_r.done_s  <= 3'h7;
         s_r.rdy_f   <= 1'b1;
         s_r.done_f  <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs.
   // ----------------------------------------------------------------
   assign MODE         = s_r.mode;
   assign CS_N         = s_r.cs_n;
   assign RD_N         = s_r.rd_n;
   assign WR_N         = s_r.wr_n;
   // R5: read mode leaves the pin to the device's open-drain ready.
   assign WR_N_OE      = s_r.mode;
   assign CHANNEL_ADDR = s_r.addr;
   // R21: code is passed on untouched, zero to all ones.
   assign RESULT       = s_r.data;
   assign RESULT_VALID = s_r.valid;
   assign BUSY         = s_r.busy;
   assign TIMEOUT      = s_r.timeout;

   // ----------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);

   strobe_needs_cs_a : assert property ((!RD_N || !WR_N) |-> !CS_N) // R23
      else $error("strobe low without chip select");
   mode_stable_a : assert property (!CS_N && !$past(CS_N) |-> $stable(MODE)) // R1
      else $error("mode changed during access");
   wr_width_a : assert property ($fell(WR_N) |-> !WR_N [*5]) // R18
      else $error("write pulse too short");
   gap_read_a : assert property ($rose(WR_N) && s_r.option == OPT_EARLY && MODE // R15
      |-> RD_N [*5] ##1 !RD_N)
      else $error("early read not after write gap");
   acq_before_a : assert property ($fell(CS_N) // R8
      |-> $past(CS_N, 4) && CHANNEL_ADDR == $past(CHANNEL_ADDR, 4))
      else $error("conversion started without acquisition");
   pipe_join_a : assert property (MODE && s_r.option == OPT_PIPE |-> RD_N == WR_N) // R19
      else $error("pipelined strobes not joined");
   read_hold_a : assert property ($fell(RD_N) && !MODE |-> !RD_N [*3]) // R4
      else $error("read released too soon");
   done_wait_a : assert property (s_r.st == ST_WAIT_DONE && !done_q |=> !RD_N) // R13
      else $error("read not issued after done");
   release_a : assert property (s_r.st == ST_END |=> CS_N && RD_N && WR_N) // R14
      else $error("strobes not released at end");
   oe_mode_a : assert property (!MODE |-> !WR_N_OE && WR_N) // R5
      else $error("ready pin driven or write low in read mode");

   read_cov_c  : cover property (!MODE && $rose(RESULT_VALID));
   early_cov_c : cover property (MODE && s_r.option == OPT_EARLY && $rose(RESULT_VALID));
   pipe_cov_c  : cover property (MODE && s_r.option == OPT_PIPE && $rose(RESULT_VALID));
   int_cov_c   : cover property (MODE && s_r.option == OPT_INTERNAL && $rose(RESULT_VALID));

endmodule

// File: hdl/conv_host_pkg.sv
package conv_host_pkg;

   // ----------------------------------------------------------------
   // Timing.
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS    = 50;
   localparam int ACQ_NS           = 160;
   localparam int WR_PULSE_NS      = 250;
   localparam int WR_TO_RD_NS      = 250;
   localparam int READ_ACCESS_NS   = 160;
   localparam int CONV_TOTAL_NS    = 660;
   localparam int RDY_TIMEOUT_NS   = 5000;
   localparam int ACQ_CYC          = (ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WR_PULSE_CYC     = (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WR_TO_RD_CYC     = (WR_TO_RD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_ACCESS_CYC  = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONV_TOTAL_CYC   = (CONV_TOTAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RDY_TIMEOUT_CYC  = RDY_TIMEOUT_NS / CLK_PERIOD_NS;
   localparam int CNT_W            = 8;

   // ----------------------------------------------------------------
   // Protocol options.
   // ----------------------------------------------------------------
   localparam logic [1:0] OPT_INTERNAL = 2'h0;
   localparam logic [1:0] OPT_EARLY    = 2'h1;
   localparam logic [1:0] OPT_PIPE     = 2'h2;

   typedef enum logic [3:0] {
      ST_IDLE, ST_ACQ, ST_RD_WAIT, ST_RD_HOLD, ST_WR_LOW,
      ST_WR_GAP, ST_WAIT_DONE, ST_READ, ST_END
   } state_t;

   typedef struct packed {
      logic       start;
      logic       mode_wr;
      logic [1:0] option;
      logic [2:0] channel;
   } request_t;

   typedef struct packed {
      state_t           st;
      logic [CNT_W-1:0] cnt;
      logic             cs_n;
      logic             rd_n;
      logic             wr_n;
      logic             mode;
      logic [2:0]       addr;
      logic [1:0]       option;
      logic [7:0]       data;
      logic             valid;
      logic             busy;
      logic             timeout;
      logic             primed;
      logic             discard;
      logic [2:0]       rdy_s;
      logic [2:0]       done_s;
      logic             rdy_f;
      logic             done_f;
   } host_state_t;

endpackage

// File: test/adc_dev_model.sv
`timescale 1ns/1ps
module adc_dev_model #(
   parameter int T_CONV = 600,
   parameter int T_INTL = 350,
   parameter int T_ACQ  = 160
) (
   // Host strobes and address
   input  wire logic        mode,
   input  wire logic        cs_n,
   input  wire logic        rd_n,
   input  wire logic        wr_n,
   input  wire logic [2:0]  addr,
   // One analog level per channel
   input  wire logic [63:0] analog,
   // Device outputs
   output logic             rdy_low,
   output logic             done_n,
   output logic [7:0]       bus,
   output int               acq_viol
);
   logic [7:0] latch;
   logic [7:0] smp;
   logic       pend;
   time        t_free;
   int         gen;
   int         g;

   initial begin
      rdy_low = 1'b0;
      done_n = 1'b1;
      latch = 8'h5A;
      pend = 1'b0;
      acq_viol = 0;
      t_free = 0;
      gen = 0;
   end

   // binary channel decode, top channel reads the upper reference
   function automatic logic [7:0] level(input logic [2:0] a);
      return (a == 3'h7) ? 8'hFF : analog[a*8 +: 8];
   endfunction

   always @(addr) t_free = $time;

   task automatic start_conv;
      if ($time - t_free < T_ACQ) acq_viol++;
      smp = level(addr);
      done_n = 1'b1;
      pend = 1'b1;
      gen++;
   endtask

   task automatic finish_conv;
      latch[3:0] = smp[3:0];
      done_n = 1'b0;
      pend = 1'b0;
      t_free = $time;
   endtask

   always @(negedge cs_n or negedge rd_n) begin
      #1;
      if (!mode && !cs_n && !rd_n) begin
         start_conv();
         rdy_low = 1'b1;
         #T_CONV;
         latch = smp;
         rdy_low = 1'b0;
         finish_conv();
      end
   end

   always @(negedge wr_n) if (mode && !cs_n) start_conv();

   // upper nibble on write rise, then internal delay
   always @(posedge wr_n) begin
      if (mode && !cs_n && pend) begin
         latch[7:4] = smp[7:4];
         g = gen;
         #T_INTL;
         if (pend && g == gen) finish_conv();
      end
   end

   always @(negedge rd_n) begin
      #1;
      if (mode && !cs_n && !rd_n && wr_n && pend) finish_conv();
   end

   // done clears on release of select or read
   always @(posedge cs_n or posedge rd_n) done_n = 1'b1;

   // latch only while selected and read; a released bus shows the inverted latch
   assign bus = (!cs_n && !rd_n) ? latch : ~latch;
endmodule

// File: test/adc_parallel_bus_interface_tb.sv
`timescale 1ns/1ps
module adc_parallel_bus_interface_tb;
   import conv_host_pkg::*;
   logic        CLOCK;
   logic        RST_N;
   request_t    REQ;
   logic        BUSY, RESULT_VALID, TIMEOUT, MODE, CS_N, RD_N, WR_N, WR_N_OE;
   logic        DONE_N, rdy_low;
   logic [7:0]  RESULT, RESULT_BUS, prev;
   logic [2:0]  CHANNEL_ADDR;
   logic [63:0] analog;
   int          err_total, n_compared, acq_viol;
   // Ready has no internal pull-up, so the board pull-up is modelled here.
   wire         wr_line = WR_N_OE ? WR_N : !rdy_low;

   conv_host u_dut (.CLOCK(CLOCK), .RST_N(RST_N), .REQ(REQ), .BUSY(BUSY),
      .RESULT_VALID(RESULT_VALID), .RESULT(RESULT), .TIMEOUT(TIMEOUT), .MODE(MODE),
      .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N), .WR_N_OE(WR_N_OE), .RDY(wr_line),
      .DONE_N(DONE_N), .RESULT_BUS(RESULT_BUS), .CHANNEL_ADDR(CHANNEL_ADDR));
   adc_dev_model u_dev (.mode(MODE), .cs_n(CS_N), .rd_n(RD_N), .wr_n(wr_line),
      .addr(CHANNEL_ADDR), .analog(analog), .rdy_low(rdy_low), .done_n(DONE_N),
      .bus(RESULT_BUS), .acq_viol(acq_viol));

   // ----------------------------------------------------------------
   // Checking and verdict
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict;
      $display("Compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   function automatic logic [7:0] level(input logic [2:0] c);
      return (c == 3'h7) ? 8'hFF : analog[c*8 +: 8];
   endfunction

   always @(negedge CLOCK) begin
      if (RST_N && !CS_N) chk("wr_oe", {7'h00, WR_N_OE}, {7'h00, MODE});
      if (RST_N && !RD_N) chk("cs_low", {7'h00, CS_N}, 8'h00);
   end

   // ----------------------------------------------------------------
   // One request, with a refused second start while busy
   // ----------------------------------------------------------------
   task automatic run(input logic mw, input logic [1:0] opt, input logic [2:0] ch);
      logic [7:0] exp;
      logic [7:0] got;
      logic       md;
      logic [2:0] ad;
      int         n;
      int         pulses;
      n = 0;
      pulses = 0;
      while (BUSY !== 1'b0 && n < 400) begin
         @(negedge CLOCK);
         // Only the power-up dummy runs here; its data must never be flagged valid.
         if (RESULT_VALID === 1'b1) pulses++;
         n++;
      end
      @(posedge CLOCK);
      REQ <= '{start: 1'b1, mode_wr: mw, option: opt, channel: ch};
      @(posedge CLOCK);
      REQ <= '{start: 1'b0, mode_wr: ~mw, option: opt, channel: ~ch};
      repeat (2) @(posedge CLOCK);
      REQ.start <= 1'b1;
      repeat (2) @(posedge CLOCK);
      REQ.start <= 1'b0;
      n = 0;
      while (BUSY !== 1'b0 && n < 400) begin
         @(negedge CLOCK);
         if (CS_N === 1'b0) begin
            md = MODE;
            ad = CHANNEL_ADDR;
         end
         if (RESULT_VALID === 1'b1) begin
            pulses++;
            got = RESULT;
         end
         n++;
      end
      chk("idle", {7'h00, BUSY}, 8'h00);
      exp = (mw && opt == OPT_PIPE) ? prev : level(ch);
      prev = level(ch);
      chk("result", got, exp);
      chk("pulses", pulses[7:0], 8'h01);
      chk("mode_pin", {7'h00, md}, {7'h00, mw});
      chk("addr", {5'h00, ad}, {5'h00, ch});
      chk("timeout", {7'h00, TIMEOUT}, 8'h00);
   endtask

   initial begin
      CLOCK = 1'b0;
      forever #25 CLOCK = ~CLOCK;
   end

   initial begin
      repeat (40000) @(posedge CLOCK);
      err_total++;
      give_verdict();
   end

   initial begin
      err_total = 0;
      n_compared = 0;
      RST_N = 1'b0;
      REQ = '0;
      void'($urandom(32'h01EC));
      analog = {$urandom, $urandom};
      analog[7:0] = 8'h00;
      // The power-up dummy conversion reads channel 0.
      prev = 8'h00;
      repeat (3) @(posedge CLOCK);
      RST_N <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         for (int c = 0; c < 8; c += 7) run(i != 0, (i == 0) ? 2'h0 : 2'(i - 1), 3'(c));
      end
      run(1'b1, OPT_PIPE, 3'h3);
      run(1'b1, OPT_PIPE, 3'h5);
      for (int i = 0; i < 20; i++) run(1'($urandom), 2'($urandom % 3), 3'($urandom));
      chk("acquire", acq_viol[7:0], 8'h00);
      give_verdict();
   end
endmodule
